// >>> spi_phase_collision_fault_logic.sv
/*
 * spi_phase_collision_fault_logic: one SPI port with polarity and
 * phase selection, write collision and master fault detection, and
 * an AXI4-Lite register file.
 * assumes sck_in, ss_n_in and the data pins are asynchronous.
 */
`timescale 1ns/10ps
module spi_phase_collision_fault_logic #(
  parameter int half_period_cycles = 2
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        clk_en,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  input  wire logic        mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  input  wire logic        miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  input  wire logic        ss_n_in,
  output logic             irq,
  output logic             wake
);
  // synchronised miso needs four cycles per half period
  if (half_period_cycles < 4 || half_period_cycles > 255) begin : g_bad_half
    $error("bad half period");
  end

  logic [1:0] sck_sync;
  logic [1:0] ss_sync;
  logic [1:0] mosi_sync;
  logic [1:0] miso_sync;
  logic       sck_prev;
  logic [7:0] control;
  logic       done_flag;
  logic       write_collision_flag_flag;
  logic       master_fault_flag_flag;
  logic       status_seen;
  logic       master_fault_flag_seen;
  logic       gmask;
  logic       deep_stop;
  logic [7:0] shifter;
  logic [7:0] rx_buf;
  logic [3:0] edge_cnt;
  logic       busy;
  logic       in_bit;
  logic [7:0] div_cnt;
  logic       sck_int;
  logic       aw_held;
  logic       w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [7:0] status_word;
  logic [1:0] power_word;

  wire run        = clk_en && !deep_stop;
  wire is_master  = control[spi_pkg::ctl_mst];
  wire enabled    = control[spi_pkg::ctl_pe];
  wire clock_idle_level_sel       = control[spi_pkg::ctl_clock_idle_level_sel];
  wire capture_edge_sel       = control[spi_pkg::ctl_capture_edge_sel];
  wire ss_low     = !ss_sync[1];
  wire sck_s      = sck_sync[1];
  wire slave_edge = enabled && !is_master && ss_low && (sck_s != sck_prev);
  wire wr_go      = aw_held && w_held && !s_axi_bvalid;
  wire wr_data    = wr_go && aw_addr == spi_pkg::off_data;
  wire wr_ctl     = wr_go && aw_addr == spi_pkg::off_control;
  wire wr_pw      = wr_go && aw_addr == spi_pkg::off_power;
  wire rd_go      = s_axi_arvalid && s_axi_arready;
  wire rd_data    = rd_go && s_axi_araddr == spi_pkg::off_data;
  wire rd_stat    = rd_go && s_axi_araddr == spi_pkg::off_status;
  wire st_access  = rd_stat || (wr_go && aw_addr == spi_pkg::off_status);
  // slave collision: selected with phase clear, or frame running
  wire collide    = busy || (!is_master && enabled && ss_low && !capture_edge_sel);
  wire mfault     = enabled && is_master && ss_low;
  wire master_go  = wr_data && enabled && is_master && !collide && !done_flag;
  wire last_edge  = edge_cnt == 4'(2 * spi_pkg::bits_per_frame - 1);
  wire m_tick     = busy && is_master && div_cnt == 8'(half_period_cycles - 1);
  wire any_edge   = m_tick || slave_edge;
  // even edges (0-based) capture when phase clear, odd when set
  wire capture    = any_edge && (edge_cnt[0] == capture_edge_sel);
  wire sample     = is_master ? miso_sync[1] : mosi_sync[1];
  // phase set: edge 0 only launches the msb
  wire shift_edge = any_edge && !capture && !(capture_edge_sel && edge_cnt == 4'h0);

  // status and power words from field positions
  always_comb begin
    status_word                   = 8'h00;
    status_word[spi_pkg::st_done] = done_flag;
    status_word[spi_pkg::st_write_collision_flag] = write_collision_flag_flag;
    status_word[spi_pkg::st_master_fault_flag] = master_fault_flag_flag;
  end
  always_comb begin
    power_word                   = 2'h0;
    power_word[spi_pkg::pw_mask] = gmask;
    power_word[spi_pkg::pw_stop] = deep_stop;
  end

  // input synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_sync  <= 2'h0;
      ss_sync   <= 2'h3;
      mosi_sync <= 2'h0;
      miso_sync <= 2'h0;
    end else if (clk_en) begin
      sck_sync  <= {sck_sync[0], sck_in};
      ss_sync   <= {ss_sync[0], ss_n_in};
      mosi_sync <= {mosi_sync[0], mosi_in};
      miso_sync <= {miso_sync[0], miso_in};
    end
  end

  // previous synchronised sck for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) sck_prev <= 1'b0;
    else if (run) sck_prev <= sck_s;
  end

  // axi write channel capture; address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[3:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
      end
    end
  end

  // write response; status is read only and answers an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= spi_pkg::resp_okay;
    end else if (clk_en) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == spi_pkg::off_status) ? spi_pkg::resp_slverr
                                                          : spi_pkg::resp_okay;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else if (clk_en) begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // axi read channel; one read outstanding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else if (clk_en) begin
      s_axi_arready <= !s_axi_rvalid && !rd_go;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= spi_pkg::resp_okay;
    end else if (clk_en) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= spi_pkg::resp_okay;
        unique case ({s_axi_araddr[3:2], 2'h0})
          spi_pkg::off_data:    s_axi_rdata <= {24'h0, rx_buf};
          spi_pkg::off_control: s_axi_rdata <= {24'h0, control};
          spi_pkg::off_status:  s_axi_rdata <= {24'h0, status_word};
          spi_pkg::off_power:   s_axi_rdata <= {30'h0, power_word};
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // power state register; deep stop is left by a write here with byte 0 strobed and bit1 clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gmask     <= 1'b1;
      deep_stop <= 1'b0;
    end else if (clk_en && wr_pw && s_axi_wstrb[0] == 1'b1) begin
      gmask     <= w_data[spi_pkg::pw_mask];
      deep_stop <= w_data[spi_pkg::pw_stop];
    end
  end

  // control register with fault overrides
  // a fault wins over any control write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      control <= spi_pkg::ctl_reset;
    end else if (run) begin
      if (mfault) begin
        control[spi_pkg::ctl_pe]  <= 1'b0;
        control[spi_pkg::ctl_mst] <= 1'b0;
      end else if (wr_ctl && s_axi_wstrb[0]) begin
        control <= w_data[7:0];
        if (master_fault_flag_flag && !master_fault_flag_seen) begin
          control[spi_pkg::ctl_pe]  <= 1'b0;
          control[spi_pkg::ctl_mst] <= 1'b0;
        end
      end
    end
  end

  // status flags; sets win over clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_flag   <= 1'b0;
      write_collision_flag_flag   <= 1'b0;
      status_seen <= 1'b0;
    end else if (run) begin
      if (st_access) status_seen <= done_flag || write_collision_flag_flag;
      if ((rd_data || wr_data) && status_seen) begin
        done_flag   <= 1'b0;
        write_collision_flag_flag   <= 1'b0;
        status_seen <= 1'b0;
      end
      if (wr_data && enabled && collide) write_collision_flag_flag <= 1'b1;
      if (any_edge && last_edge) done_flag <= 1'b1;
    end
  end

  // master fault flag and its clear sequence; a new fault wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      master_fault_flag_flag <= 1'b0;
      master_fault_flag_seen <= 1'b0;
    end else if (run) begin
      if (st_access) master_fault_flag_seen <= master_fault_flag_flag;
      if (wr_ctl && master_fault_flag_seen) begin
        master_fault_flag_flag <= 1'b0;
        master_fault_flag_seen <= 1'b0;
      end
      if (mfault) master_fault_flag_flag <= 1'b1;
    end
  end

  // shift engine: capture edges sample, the other edges shift except edge 0 with phase set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shifter  <= 8'h00;
      rx_buf   <= 8'h00;
      in_bit   <= 1'b0;
      edge_cnt <= 4'h0;
      busy     <= 1'b0;
      div_cnt  <= 8'h00;
      sck_int  <= 1'b0;
    end else if (run) begin
      div_cnt <= m_tick || !busy ? 8'h00 : div_cnt + 8'h01;
      if (!enabled || mfault) begin
        busy     <= 1'b0;
        edge_cnt <= 4'h0;
        sck_int  <= 1'b0;
      end else if (master_go) begin
        shifter  <= w_data[7:0];
        busy     <= 1'b1;
        edge_cnt <= 4'h0;
      end else if (wr_data && !is_master && !collide && !done_flag) begin
        shifter <= w_data[7:0];
      end else if (any_edge) begin
        if (!is_master && edge_cnt == 4'h0) busy <= 1'b1;
        if (m_tick) sck_int <= !sck_int;
        if (capture) in_bit <= sample;
        if (shift_edge) shifter <= {shifter[6:0], in_bit};
        edge_cnt <= last_edge ? 4'h0 : edge_cnt + 4'h1;
        if (last_edge) begin
          busy    <= 1'b0;
          sck_int <= 1'b0;
          if (capture_edge_sel) shifter <= {shifter[6:0], sample};
          if (!done_flag) begin
            rx_buf <= capture_edge_sel ? {shifter[6:0], sample} : {shifter[6:0], in_bit};
          end
        end
      end
      if (!is_master && !ss_low && !capture_edge_sel) edge_cnt <= 4'h0;
    end
  end

  // pin drivers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_out  <= 1'b0;
      sck_oe   <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe  <= 1'b0;
      miso_out <= 1'b0;
      miso_oe  <= 1'b0;
    end else if (clk_en) begin
      sck_out  <= clock_idle_level_sel ^ (busy && sck_int);
      sck_oe   <= enabled && is_master;
      mosi_out <= shifter[7];
      mosi_oe  <= enabled && is_master;
      miso_out <= shifter[7];
      miso_oe  <= enabled && !is_master && ss_low && (busy || !capture_edge_sel);
    end
  end

  // shared interrupt and wake; write collision never reaches them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq  <= 1'b0;
      wake <= 1'b0;
    end else if (clk_en) begin
      irq  <= control[spi_pkg::ctl_ie] && (done_flag || master_fault_flag_flag) && !gmask;
      wake <= !deep_stop && control[spi_pkg::ctl_ie]
              && (done_flag || master_fault_flag_flag);
    end
  end
endmodule : spi_phase_collision_fault_logic

// >>> spi_pkg.sv
/*
 * spi_pkg: register offsets, field positions, reset values and bus
 * response codes shared by the serial peripheral block.
 * assumes a 32-bit AXI4-Lite register bus with one register per word.
 */
package spi_pkg;
  localparam logic [3:0] off_data    = 4'h0;
  localparam logic [3:0] off_control = 4'h4;
  localparam logic [3:0] off_status  = 4'h8;
  localparam logic [3:0] off_power   = 4'hC;
  // control field positions
  localparam int ctl_ie   = 7;
  localparam int ctl_pe   = 6;
  localparam int ctl_div  = 5;
  localparam int ctl_mst  = 4;
  localparam int ctl_clock_idle_level_sel = 3;
  localparam int ctl_capture_edge_sel = 2;
  localparam logic [7:0] ctl_reset = 8'h00;
  // status field positions
  localparam int st_done = 7;
  localparam int st_write_collision_flag = 6;
  localparam int st_master_fault_flag = 4;
  // power register: bit0 global mask, bit1 deep stop
  localparam int pw_mask = 0;
  localparam int pw_stop = 1;
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  localparam int bits_per_frame = 8;
endpackage : spi_pkg

// >>> spi_checker_props.sv
/* checker: bus answers, fault release and pin drive of the spi block
   assumes binding to the block's top module ports */
`timescale 1ns/10ps
module spi_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        sck_oe,
  input wire logic        miso_oe,
  input wire logic        ss_n_in
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer unstable");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_fault_drop: assert property ((sck_oe && !ss_n_in) ##1 !ss_n_in [*6] |-> !sck_oe)
    else $error("master kept driving under fault");
  a_slave_quiet: assert property (ss_n_in [*4] |-> !miso_oe)
    else $error("deselected slave drives miso");
  a_master_no_miso: assert property (sck_oe |-> !miso_oe)
    else $error("master drives miso");
endmodule : spi_checker
bind spi_phase_collision_fault_logic spi_checker chk_u (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .sck_oe, .miso_oe, .ss_n_in);

// >>> spi_slave_model.sv
/* partner: behavioural spi slave facing the block as master
   assumes the bench selects it and sets its mode and byte */
`timescale 1ns/10ps
module spi_slave_model (
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic       clock_idle_level_sel,
  input  wire logic       capture_edge_sel,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  int bits = 0;
  initial miso = 1'b0;
  initial rx = 8'h00;
  always @(negedge ss_n) begin
    bits = 0;
    if (!capture_edge_sel) miso = tx[7];
  end
  // released line flips rather than holding
  always @(posedge ss_n) miso = ~miso;
  always @(sck) begin
    if (!ss_n && bits < 8) begin
      if (sck ^ clock_idle_level_sel ^ capture_edge_sel) begin
        rx = {rx[6:0], mosi};
        bits++;
      end else miso = tx[7 - bits];
    end
  end
endmodule : spi_slave_model

// >>> spi_phase_collision_fault_logic_tb.sv
/* bench: register, master, fault and slave scenarios for the spi block
   assumes the partner slave model and the checker bind */
`timescale 1ns/10ps
module spi_phase_collision_fault_logic_tb;
  localparam logic [3:0] dat = spi_pkg::off_data;
  localparam logic [3:0] ctl = spi_pkg::off_control;
  localparam logic [3:0] st  = spi_pkg::off_status;
  localparam logic [3:0] pw  = spi_pkg::off_power;
  logic        aclk, aresetn, clk_en, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, irq, wake, ss_n_in;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, s_miso;
  logic        tb_sck, tb_mosi, m_ss, m_clock_idle_level_sel, m_capture_edge_sel;
  logic [7:0]  m_tx, m_rx, got;
  int          fail_count = 0;
  int          checked = 0;
  wire         sck_in  = sck_oe ? sck_out : tb_sck;
  wire         mosi_in = mosi_oe ? mosi_out : tb_mosi;
  wire         miso_in = miso_oe ? miso_out : s_miso;
  spi_phase_collision_fault_logic #(.half_period_cycles(4)) dut_u (
    .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sck_in, .sck_out,
    .sck_oe, .mosi_in, .mosi_out, .mosi_oe, .miso_in, .miso_out, .miso_oe,
    .ss_n_in, .irq, .wake);
  spi_slave_model part_u (.sck(sck_in), .mosi(mosi_in), .ss_n(m_ss), .clock_idle_level_sel(m_clock_idle_level_sel),
    .capture_edge_sel(m_capture_edge_sel), .tx(m_tx), .miso(s_miso), .rx(m_rx));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
    tick(1);
  endtask : rd
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      rd(st);
      n++;
    end while (!v[7] && n < 100);
  endtask : wait_done
  task automatic t_reset();
    rd(ctl);
    chk(v, 32'h0);
    rd(st);
    chk(v, 32'h0);
    rd(pw);
    chk(v, 32'h1);
    wr(st, 8'hFF);
    chk(32'(r), 32'(spi_pkg::resp_slverr));
  endtask : t_reset
  task automatic t_master(input logic [1:0] m);
    {m_clock_idle_level_sel, m_capture_edge_sel} <= m;
    m_tx <= 8'h3C ^ {6'h00, m};
    wr(ctl, {4'h5, m, 2'h0});
    chk(32'(sck_in), 32'(m[1]));
    m_ss <= 1'b0;
    wr(dat, 8'hA5 ^ {6'h00, m});
    wr(dat, 8'hFF);
    wait_done();
    chk(v, 32'hC0);
    rd(dat);
    chk(v, 32'h3C ^ 32'(m));
    chk(32'(m_rx), 32'hA5 ^ 32'(m));
    chk(32'(sck_in), 32'(m[1]));
    m_ss <= 1'b1;
  endtask : t_master
  task automatic t_fault();
    wr(pw, 8'h00);
    wr(ctl, 8'hD0);
    ss_n_in <= 1'b0;
    tick(8);
    chk(32'(irq), 32'h1);
    chk(32'(wake), 32'h1);
    rd(ctl);
    chk(v, 32'h80);
    wr(ctl, 8'hD0);
    rd(ctl);
    chk(v, 32'h80);
    ss_n_in <= 1'b1;
    wr(pw, 8'h02);
    tick(3);
    chk(32'(wake), 32'h0);
    wr(pw, 8'h00);
    rd(st);
    chk(v, 32'h10);
    wr(ctl, 8'hD0);
    rd(st);
    chk(v, 32'h0);
    rd(ctl);
    chk(v, 32'hD0);
    chk(32'(irq), 32'h0);
  endtask : t_fault
  task automatic t_slave(input logic c);
    logic [7:0] d;
    d = 8'h5A;
    wr(ctl, {5'h18, c, 2'h0});
    wr(dat, 8'h81);
    ss_n_in <= 1'b0;
    tick(4);
    wr(dat, 8'h42);
    rd(st);
    chk(v, c ? 32'h0 : 32'h40);
    chk(32'(irq), 32'h0);
    for (int i = 7; i >= 0; i--) begin
      if (!c) tb_mosi <= d[i];
      tick(4);
      if (c && i < 7) got[i + 1] = miso_in;
      tb_sck <= 1'b1;
      if (c) tb_mosi <= d[i];
      tick(4);
      if (!c) got[i] = miso_in;
      tb_sck <= 1'b0;
    end
    tick(4);
    if (c) got[0] = miso_in;
    chk(32'(got), c ? 32'h42 : 32'h81);
    wait_done();
    chk(v, c ? 32'h80 : 32'hC0);
    chk(32'(irq), 32'h1);
    rd(dat);
    chk(v, 32'h5A);
    ss_n_in <= 1'b1;
    tick(4);
  endtask : t_slave
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    #2000000;
    fail_count++;
    final_report();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_rready, tb_sck, tb_mosi, m_clock_idle_level_sel, m_capture_edge_sel} = '0;
    {clk_en, ss_n_in, m_ss} = '1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, m_tx} = '0;
    s_axi_wstrb = 4'hF;
    tick(2);
    aresetn <= 1'b1;
    tick(1);
    t_reset();
    for (int m = 0; m < 4; m++) t_master(2'(m));
    t_fault();
    t_slave(1'b0);
    t_slave(1'b1);
    final_report();
  end
endmodule : spi_phase_collision_fault_logic_tb
